// file: verilog/qbs_port.v
// burst-of-four ddr sram port with echo clocks, valid flag and loop bypass
`timescale 1ns/1ps
`include "qbs_defs.vh"
module qbs_port
(
  input  wire                    clock,
  input  wire                    reset_n,
  input  wire                    ce,
  input  wire                    k_clk_in,
  input  wire                    k_clk_inv_in,
  input  wire                    rd_select_n,
  input  wire                    wr_select_n,
  input  wire [`QBS_ADDR_W-1:0]  addr_in,
  input  wire [`QBS_DATA_W-1:0]  wr_bus_in,
  input  wire [`QBS_LANES-1:0]   lane_wr_mask_n,
  input  wire                    loop_bypass_n,
  input  wire                    wide_org,
  output reg  [`QBS_DATA_W-1:0]  rd_bus_out,
  output reg                     echo_tim,
  output reg                     echo_tim_inv,
  output reg                     out_valid,
  output reg                     loop_locked,
  output wire                    wr_buf_ready
);
  localparam IW  = `QBS_MEM_AW + 2;
  localparam FW  = IW + `QBS_DATA_W + `QBS_LANES;
  localparam PW  = 2 + 2 + `QBS_ADDR_W + `QBS_DATA_W + `QBS_LANES + 2;

  // ****************************************
  // pin synchronisers
  // ****************************************
  wire [PW-1:0]              pin_raw;
  wire [PW-1:0]              pin_s;
  wire                       k_s;
  wire                       kn_s;
  wire                       rd_n_s;
  wire                       wr_n_s;
  wire [`QBS_ADDR_W-1:0]     addr_s;
  wire [`QBS_DATA_W-1:0]     data_s;
  wire [`QBS_LANES-1:0]      mask_n_s;
  wire                       bypass_n_s;
  wire                       wide_s;

  // data travels with the clocks so every beat sees the same delay
  assign pin_raw = {k_clk_in, k_clk_inv_in, rd_select_n, wr_select_n, addr_in,
                    wr_bus_in, lane_wr_mask_n, loop_bypass_n, wide_org};
  assign {k_s, kn_s, rd_n_s, wr_n_s, addr_s, data_s, mask_n_s, bypass_n_s, wide_s} = pin_s;

  qbs_sync #(.WIDTH(PW)) u_sync
  (
    .clock   (clock),
    .reset_n (reset_n),
    .ce      (ce),
    .d       (pin_raw),
    .q       (pin_s)
  );

  // ****************************************
  // link clock edge detection
  // ****************************************
  reg  k_d;
  reg  kn_d;
  wire k_rise;
  wire kn_rise;
  wire edge_any;

  assign k_rise   = k_s & ~k_d;
  assign kn_rise  = kn_s & ~kn_d;
  // relies on the complementary clock sitting near mid period
  assign edge_any = k_rise | kn_rise;

  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      k_d  <= 1'b0;
      kn_d <= 1'b0;
    end
    else if (ce)
    begin
      k_d  <= k_s;
      kn_d <= kn_s;
    end
  end

  // ****************************************
  // loop lock tracking
  // ****************************************
  reg [`QBS_LOCK_CW-1:0] lock_cnt;
  wire [3:0]             rd_lat;

  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lock_cnt    <= {`QBS_LOCK_CW{1'b0}};
      loop_locked <= 1'b0;
    end
    else if (ce)
    begin
      if (!bypass_n_s)
      begin
        lock_cnt    <= {`QBS_LOCK_CW{1'b0}};
        loop_locked <= 1'b0;
      end
      else if (lock_cnt == `QBS_LOCK_CYCLES - 1)
        loop_locked <= 1'b1;
      else
        lock_cnt <= lock_cnt + 1'b1;
    end
  end

  // bypass mode is only safe at the lower clock rate
  assign rd_lat = bypass_n_s ? `QBS_LAT_DLL_ON : `QBS_LAT_DLL_OFF;

  // ****************************************
  // command capture
  // ****************************************
  wire rd_cmd;
  wire wr_cmd;

  // commands only at a true rising edge, so reads and writes coexist
  assign rd_cmd = k_rise & ~rd_n_s;
  assign wr_cmd = k_rise & ~wr_n_s;

  // ****************************************
  // burst slots, two in flight per direction
  // ****************************************
  reg  [1:0]             rd_v;
  reg  [3:0]             rd_cnt [0:1];
  reg  [`QBS_MEM_AW-1:0] rd_addr [0:1];
  reg  [1:0]             wr_v;
  reg  [3:0]             wr_cnt [0:1];
  reg  [`QBS_MEM_AW-1:0] wr_addr [0:1];
  wire [1:0]             rd_take;
  wire [1:0]             wr_take;
  wire [1:0]             rd_beat;
  wire [1:0]             wr_beat;
  wire [1:0]             rd_idx [0:1];
  wire [1:0]             wr_idx [0:1];

  // a third request while two are in flight is dropped
  assign rd_take[0] = rd_cmd & ~rd_v[0];
  assign rd_take[1] = rd_cmd & rd_v[0] & ~rd_v[1];
  assign wr_take[0] = wr_cmd & ~wr_v[0];
  assign wr_take[1] = wr_cmd & wr_v[0] & ~wr_v[1];

  genvar s;
  generate
    for (s = 0; s < 2; s = s + 1)
    begin : g_slot
      wire [3:0] rd_nxt;
      wire [3:0] wr_nxt;
      wire [3:0] rd_off;
      wire [3:0] wr_off;

      assign rd_nxt     = rd_cnt[s] + 4'h1;
      assign wr_nxt     = wr_cnt[s] + 4'h1;
      assign rd_off     = rd_nxt - rd_lat;
      assign wr_off     = wr_nxt - `QBS_WR_FIRST;
      // beats on every half-cycle edge once latency has run out
      assign rd_beat[s] = rd_v[s] & edge_any & (rd_nxt >= rd_lat) & (rd_off <= `QBS_BURST_LAST);
      // write beats one cycle after command, then on every half-cycle edge
      assign wr_beat[s] = wr_v[s] & edge_any & (wr_nxt >= `QBS_WR_FIRST) & (wr_off <= `QBS_BURST_LAST);
      assign rd_idx[s]  = rd_off[1:0];
      assign wr_idx[s]  = wr_off[1:0];

      always @(posedge clock or negedge reset_n)
      begin
        if (!reset_n)
        begin
          rd_v[s]    <= 1'b0;
          rd_cnt[s]  <= 4'h0;
          rd_addr[s] <= {`QBS_MEM_AW{1'b0}};
          wr_v[s]    <= 1'b0;
          wr_cnt[s]  <= 4'h0;
          wr_addr[s] <= {`QBS_MEM_AW{1'b0}};
        end
        else if (ce)
        begin
          if (rd_take[s])
          begin
            rd_v[s]    <= 1'b1;
            rd_cnt[s]  <= 4'h0;
            rd_addr[s] <= addr_s[`QBS_MEM_AW-1:0];
          end
          else if (rd_v[s] && edge_any)
          begin
            rd_cnt[s] <= rd_nxt;
            if (rd_beat[s] && rd_off == `QBS_BURST_LAST)
              rd_v[s] <= 1'b0;
          end
          if (wr_take[s])
          begin
            wr_v[s]    <= 1'b1;
            wr_cnt[s]  <= 4'h0;
            wr_addr[s] <= addr_s[`QBS_MEM_AW-1:0];
          end
          else if (wr_v[s] && edge_any)
          begin
            wr_cnt[s] <= wr_nxt;
            if (wr_beat[s] && wr_off == `QBS_BURST_LAST)
              wr_v[s] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // write beat buffer
  // ****************************************
  wire [IW-1:0]          push_idx;
  wire [`QBS_DATA_W-1:0] push_data;
  wire [`QBS_LANES-1:0]  push_mask_n;
  wire [FW-1:0]          push_word;
  wire                   push;
  wire                   pop_valid;
  wire                   pop_ready;
  wire [FW-1:0]          pop_word;
  wire [IW-1:0]          pop_idx;
  wire [`QBS_DATA_W-1:0] pop_data;
  wire [`QBS_LANES-1:0]  pop_mask_n;
  wire                   rd_launch;

  assign push      = |wr_beat;
  assign push_idx  = wr_beat[0] ? {wr_addr[0], wr_idx[0]} : {wr_addr[1], wr_idx[1]};
  // narrow organisation ignores the upper half and its lanes
  assign push_data = wide_s ? data_s : {{`QBS_HALF_W{1'b0}}, data_s[`QBS_HALF_W-1:0]};
  // lane mask taken on the same edge as its data beat
  assign push_mask_n = wide_s ? mask_n_s : {2'b11, mask_n_s[1:0]};
  assign push_word = {push_idx, push_data, push_mask_n};
  assign {pop_idx, pop_data, pop_mask_n} = pop_word;
  // the array is single ported, read launches win and the buffer waits
  assign pop_ready = ~rd_launch;

  qbs_fifo #(.WIDTH(FW), .DEPTH(`QBS_FIFO_DEPTH), .AW(`QBS_FIFO_AW)) u_fifo
  (
    .clock     (clock),
    .reset_n   (reset_n),
    .ce        (ce),
    .in_valid  (push),
    .in_ready  (wr_buf_ready),
    .in_data   (push_word),
    .out_valid (pop_valid),
    .out_ready (pop_ready),
    .out_data  (pop_word)
  );

  // ****************************************
  // storage array
  // ****************************************
  reg [`QBS_DATA_W-1:0] mem [0:(1 << IW)-1];

  genvar l;
  generate
    for (l = 0; l < `QBS_LANES; l = l + 1)
    begin : g_lane
      always @(posedge clock)
      begin
        if (ce && pop_valid && pop_ready && !pop_mask_n[l])
          mem[pop_idx][l*`QBS_LANE_W +: `QBS_LANE_W] <= pop_data[l*`QBS_LANE_W +: `QBS_LANE_W];
      end
    end
  endgenerate

  // ****************************************
  // read launch and echo clocks
  // ****************************************
  wire [IW-1:0]          rd_mem_idx;
  wire [`QBS_DATA_W-1:0] rd_word;

  // limitation: a read right behind a write may see it still buffered
  assign rd_launch  = |rd_beat;
  assign rd_mem_idx = rd_beat[0] ? {rd_addr[0], rd_idx[0]} : {rd_addr[1], rd_idx[1]};
  assign rd_word    = mem[rd_mem_idx];

  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rd_bus_out   <= {`QBS_DATA_W{1'b0}};
      out_valid    <= 1'b0;
      echo_tim     <= 1'b0;
      echo_tim_inv <= 1'b1;
    end
    else if (ce)
    begin
      // echo clocks run free from the input clock pair
      if (k_rise)
      begin
        echo_tim     <= 1'b1;
        echo_tim_inv <= 1'b0;
      end
      else if (kn_rise)
      begin
        echo_tim     <= 1'b0;
        echo_tim_inv <= 1'b1;
      end
      if (edge_any)
      begin
        if (rd_launch)
        begin
          rd_bus_out <= wide_s ? rd_word : {{`QBS_HALF_W{1'b0}}, rd_word[`QBS_HALF_W-1:0]};
          out_valid  <= 1'b1;
        end
        else
        begin
          rd_bus_out <= {`QBS_DATA_W{1'b0}};
          out_valid  <= 1'b0;
        end
      end
    end
  end
endmodule

// file: common/qbs_defs.vh
// constants of the burst sram port: widths, latencies, timing counts
`ifndef QBS_DEFS_VH
`define QBS_DEFS_VH

// ****************************************
// widths
// ****************************************
`define QBS_DATA_W      36
`define QBS_HALF_W      18
`define QBS_ADDR_W      20
`define QBS_MEM_AW      6
`define QBS_LANES       4
`define QBS_LANE_W      9
`define QBS_FIFO_DEPTH  4
`define QBS_FIFO_AW     2

// ****************************************
// latencies in half-cycle edges of the link clock
// ****************************************
`define QBS_LAT_DLL_ON  4'h5
`define QBS_LAT_DLL_OFF 4'h2
`define QBS_WR_FIRST    4'h2
`define QBS_BURST_LAST  4'h3

// ****************************************
// timing
// ****************************************
`define QBS_CLK_PERIOD_PS 25000
`define QBS_LOCK_TIME_NS  20000
`define QBS_LOCK_CYCLES   ((`QBS_LOCK_TIME_NS * 1000 + `QBS_CLK_PERIOD_PS - 1) / `QBS_CLK_PERIOD_PS)
`define QBS_LOCK_CW       10

`endif

// file: verilog/qbs_sync.v
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module qbs_sync
#(
  parameter WIDTH = 1
)
(
  input  wire             clock,
  input  wire             reset_n,
  input  wire             ce,
  input  wire [WIDTH-1:0] d,
  output reg  [WIDTH-1:0] q
);
  reg [WIDTH-1:0] meta;

  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta <= {WIDTH{1'b0}};
      q    <= {WIDTH{1'b0}};
    end
    else if (ce)
    begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// file: verilog/qbs_fifo.v
// small valid/ready fifo between write beat capture and the array
`timescale 1ns/1ps
module qbs_fifo
#(
  parameter WIDTH = 48,
  parameter DEPTH = 4,
  parameter AW    = 2
)
(
  input  wire             clock,
  input  wire             reset_n,
  input  wire             ce,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] store [0:DEPTH-1];
  reg [AW:0]      wr_ptr;
  reg [AW:0]      rd_ptr;
  wire            full;
  wire            empty;

  assign empty     = (wr_ptr == rd_ptr);
  assign full      = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign in_ready  = ~full;
  assign out_valid = ~empty;
  assign out_data  = store[rd_ptr[AW-1:0]];

  always @(posedge clock)
  begin
    if (ce && in_valid && !full)
      store[wr_ptr[AW-1:0]] <= in_data;
  end

  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
    end
    else if (ce)
    begin
      if (in_valid && !full)
        wr_ptr <= wr_ptr + 1'b1;
      if (out_ready && !empty)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule

// file: tb/qbs_ctl_model.sv
// controller model driving link clocks, commands, address and write beats
`timescale 1ns/1ps
`include "qbs_defs.vh"
module qbs_ctl_model
(
  output reg                    k_clk_in,
  output wire                   k_clk_inv_in,
  output reg                    rd_select_n,
  output reg                    wr_select_n,
  output reg  [`QBS_ADDR_W-1:0] addr_in,
  output reg  [`QBS_DATA_W-1:0] wr_bus_in,
  output reg  [`QBS_LANES-1:0]  lane_wr_mask_n
);
  // ********
  // link clock pair, 5 MHz, well under bypass limit
  // ********
  initial
  begin
    k_clk_in = 1'b0;
    rd_select_n = 1'b1;
    wr_select_n = 1'b1;
    addr_in = 20'h00000;
    wr_bus_in = 36'h000000000;
    lane_wr_mask_n = 4'hF;
    #7;
    forever #100 k_clk_in = ~k_clk_in;
  end
  assign k_clk_inv_in = ~k_clk_in;

  // ********
  // commands change at k fall, half a period clear of the rise
  // ********
  // one step behind the write task, so a shared address is never driven twice at once
  task rd_cmd(input [19:0] a);
  begin
    @(negedge k_clk_in);
    #1;
    addr_in = a;
    rd_select_n = 1'b0;
    @(negedge k_clk_in);
    #1;
    rd_select_n = 1'b1;
    addr_in = ~a;
  end
  endtask

  task wr_cmd(input [19:0] a, input [143:0] d, input [15:0] m);
    integer i;
  begin
    @(negedge k_clk_in);
    addr_in = a;
    wr_select_n = 1'b0;
    @(negedge k_clk_in);
    wr_select_n = 1'b1;
    addr_in = ~a;
    #50;
    for (i = 0; i < 4; i = i + 1)
    begin
      wr_bus_in = d[i*36 +: 36];
      lane_wr_mask_n = m[i*4 +: 4];
      #100;
    end
    wr_bus_in = ~wr_bus_in;
    lane_wr_mask_n = 4'hF;
  end
  endtask
endmodule

// file: tb/qbs_port_checker.sv
// assertions on the burst sram port outputs
`timescale 1ns/1ps
`include "qbs_defs.vh"
module qbs_port_checker
(
  input wire                   clock,
  input wire                   reset_n,
  input wire                   loop_bypass_n,
  input wire                   wide_org,
  input wire [`QBS_DATA_W-1:0] rd_bus_out,
  input wire                   echo_tim,
  input wire                   echo_tim_inv,
  input wire                   out_valid,
  input wire                   loop_locked
);
  // ********
  // clocks since loop bypass released; saturates to stay small
  // ********
  int lock_cnt;
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      lock_cnt <= 0;
    else if (!loop_bypass_n)
      lock_cnt <= 0;
    else if (lock_cnt < 4000)
      lock_cnt <= lock_cnt + 1;
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  // ********
  // assertions
  // ********
  a_echo_pair: assert property (echo_tim_inv == !echo_tim)
    else $error("echo pair not complementary");
  a_echo_high: assert property ($rose(echo_tim) |=> echo_tim [*3] ##1 !echo_tim)
    else $error("echo high phase wrong length");
  a_echo_low: assert property ($fell(echo_tim) |=> !echo_tim [*3] ##1 echo_tim)
    else $error("echo low phase wrong length");
  a_valid_on_echo: assert property (!$stable(out_valid) |-> !$stable(echo_tim))
    else $error("valid moved without echo edge");
  a_data_on_echo: assert property (!$stable(rd_bus_out) |-> !$stable(echo_tim))
    else $error("read data moved without echo edge");
  a_idle_bus: assert property (!out_valid |-> rd_bus_out == 36'h000000000)
    else $error("read bus busy while not valid");
  a_burst_len: assert property ($fell(out_valid) |-> $past(out_valid, 16))
    else $error("burst shorter than four beats");
  a_first_beat: assert property ($rose(out_valid) |-> echo_tim == !loop_bypass_n)
    else $error("first beat on wrong clock phase");
  a_narrow_upper: assert property (!wide_org && !$past(wide_org, 4) |-> rd_bus_out[35:18] == 18'h00000)
    else $error("upper read bits driven in narrow mode");
  a_lock_time: assert property ($rose(loop_locked) |-> lock_cnt >= `QBS_LOCK_CYCLES)
    else $error("lock reported too early");
  a_bypass_drop: assert property ($fell(loop_bypass_n) |-> ##[1:4] !loop_locked)
    else $error("lock kept while loop bypassed");
endmodule

bind qbs_port qbs_port_checker u_qbs_port_checker
(
  .clock         (clock),
  .reset_n       (reset_n),
  .loop_bypass_n (loop_bypass_n),
  .wide_org      (wide_org),
  .rd_bus_out    (rd_bus_out),
  .echo_tim      (echo_tim),
  .echo_tim_inv  (echo_tim_inv),
  .out_valid     (out_valid),
  .loop_locked   (loop_locked)
);

// file: tb/tb.sv
// self-checking bench for the burst sram port
`timescale 1ns/1ps
`include "qbs_defs.vh"
module tb;
  reg         clock;
  reg         reset_n;
  reg         loop_bypass_n;
  reg         wide_org;
  wire        k_clk_in;
  wire        k_clk_inv_in;
  wire        rd_select_n;
  wire        wr_select_n;
  wire [19:0] addr_in;
  wire [35:0] wr_bus_in;
  wire [3:0]  lane_wr_mask_n;
  wire [35:0] rd_bus_out;
  wire        echo_tim;
  wire        echo_tim_inv;
  wire        out_valid;
  wire        loop_locked;
  wire        wr_buf_ready;
  reg  [35:0] exp_mem [0:255];
  integer     n_mismatch;
  integer     samples_checked;
  integer     cycles;

  qbs_ctl_model u_qbs_ctl_model (.k_clk_in(k_clk_in), .k_clk_inv_in(k_clk_inv_in), .rd_select_n(rd_select_n),
    .wr_select_n(wr_select_n), .addr_in(addr_in), .wr_bus_in(wr_bus_in), .lane_wr_mask_n(lane_wr_mask_n));
  qbs_port u_qbs_port (.clock(clock), .reset_n(reset_n), .ce(1'b1), .k_clk_in(k_clk_in),
    .k_clk_inv_in(k_clk_inv_in), .rd_select_n(rd_select_n), .wr_select_n(wr_select_n), .addr_in(addr_in),
    .wr_bus_in(wr_bus_in), .lane_wr_mask_n(lane_wr_mask_n), .loop_bypass_n(loop_bypass_n), .wide_org(wide_org),
    .rd_bus_out(rd_bus_out), .echo_tim(echo_tim), .echo_tim_inv(echo_tim_inv), .out_valid(out_valid),
    .loop_locked(loop_locked), .wr_buf_ready(wr_buf_ready));

  // ********
  // clock, timeout, shared tasks
  // ********
  initial clock = 1'b0;
  always #12.5 clock = ~clock;
  always @(posedge clock)
  begin
    cycles = cycles + 1;
    if (cycles == 8000)
    begin
      n_mismatch = n_mismatch + 1;
      summarize;
    end
  end

  task chk(input [35:0] got, input [35:0] want);
  begin
    samples_checked = samples_checked + 1;
    if (got !== want)
    begin
      n_mismatch = n_mismatch + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
    end
  end
  endtask

  // expectation follows lane masks; narrow mode writes lower lanes only
  task wr(input [5:0] a, input [143:0] d, input [15:0] m);
    integer i;
    integer j;
  begin
    for (i = 0; i < 4; i = i + 1)
      for (j = 0; j < 4; j = j + 1)
        if (!m[i*4+j] && (wide_org || j < 2))
          exp_mem[{a, i[1:0]}][j*9 +: 9] = d[i*36 + j*9 +: 9];
    u_qbs_ctl_model.wr_cmd({14'h0000, a}, d, m);
  end
  endtask

  // samples each beat mid-way through its half cycle
  task rd(input [5:0] a, input integer lat);
    integer i;
    reg [35:0] w;
  begin
    u_qbs_ctl_model.rd_cmd({14'h0000, a});
    #(lat * 100);
    for (i = 0; i < 4; i = i + 1)
    begin
      w = exp_mem[{a, i[1:0]}];
      if (!wide_org)
        w[35:18] = 18'h00000;
      chk(rd_bus_out, w);
      chk(out_valid, 1'b1);
      chk(echo_tim, ((lat + i) % 2 == 0));
      chk(echo_tim_inv, ((lat + i) % 2 != 0));
      #100;
    end
    chk(out_valid, 1'b0);
    chk(rd_bus_out, 36'h000000000);
  end
  endtask

  task wait_clk(input integer n);
  begin
    repeat (n) @(posedge clock);
    #2;
  end
  endtask

  // ********
  // scenarios
  // ********
  task t_basic;
  begin
    wr(6'h03, {36'h123456789, 36'h9ABCDEF01, 36'h2468ACE13, 36'hFEDCBA987}, 16'h0000);
    wr(6'h04, {36'hEDCBA9876, 36'h654321FED, 36'hDB97531EC, 36'h012345678}, 16'h0000);
    rd(6'h03, 5);
    rd(6'h04, 5);
    wr(6'h03, {4{36'h555555555}}, 16'h96C3);
    rd(6'h03, 5);
  end
  endtask

  task t_conc;
  begin
    fork
      rd(6'h04, 5);
      wr(6'h04, {36'h13579BDF0, 36'h2468ACE02, 36'h0FEDCBA98, 36'h876543210}, 16'h0000);
    join
    rd(6'h04, 5);
  end
  endtask

  task t_narrow;
  begin
    wait_clk(1);
    wide_org = 1'b0;
    wait_clk(8);
    wr(6'h0C, {4{36'hFFFFFFFFF}}, 16'h0000);
    rd(6'h0C, 5);
    wait_clk(1);
    wide_org = 1'b1;
    wait_clk(8);
  end
  endtask

  task t_lock;
  begin
    while (cycles < 780)
      wait_clk(1);
    chk(loop_locked, 1'b0);
    while (cycles < 840)
      wait_clk(1);
    chk(loop_locked, 1'b1);
    loop_bypass_n = 1'b0;
    wait_clk(6);
    chk(loop_locked, 1'b0);
    rd(6'h03, 2);
    wait_clk(1);
    loop_bypass_n = 1'b1;
    wait_clk(20);
    chk(loop_locked, 1'b0);
  end
  endtask

  // write buffer seen through the port: never refuses a burst, drains into the array
  task t_wbuf;
    integer i;
  begin
    fork
      wr(6'h05, {36'h0A0A0A0A0, 36'h1B1B1B1B1, 36'h2C2C2C2C2, 36'h3D3D3D3D3}, 16'h0000);
      for (i = 0; i < 5; i = i + 1)
      begin
        wait_clk(4);
        chk(wr_buf_ready, 1'b1);
      end
    join
    chk(out_valid, 1'b0);
    chk(rd_bus_out, 36'h000000000);
    rd(6'h05, 5);
  end
  endtask

  task summarize;
  begin
    $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask

  initial
  begin
    n_mismatch = 0;
    samples_checked = 0;
    cycles = 0;
    reset_n = 1'b0;
    loop_bypass_n = 1'b1;
    wide_org = 1'b1;
    wait_clk(4);
    reset_n = 1'b1;
    wait_clk(1);
    chk(rd_bus_out, 36'h000000000);
    chk(wr_buf_ready, 1'b1);
    t_basic;
    t_conc;
    t_narrow;
    t_lock;
    t_wbuf;
    summarize;
  end
endmodule
